/* File: hdl/cfbt_regs.svh */
`ifndef CFBT_REGS_SVH
`define CFBT_REGS_SVH

// ---------------------------------------------------------------
// Byte offsets on the register bus
// ---------------------------------------------------------------
`define CFBT_OFS_FLAGS 5'h00
`define CFBT_OFS_CFG2  5'h04
`define CFBT_OFS_IEN   5'h08
`define CFBT_OFS_ICLR  5'h0c
`define CFBT_OFS_STAT  5'h10

// ---------------------------------------------------------------
// Interrupt flag register bit positions
// ---------------------------------------------------------------
`define CFBT_B_ANY_ERROR_WARNING 8
`define CFBT_B_BAD   7
`define CFBT_B_WAKE  6
`define CFBT_B_ERR   5
`define CFBT_B_FIFO  3
`define CFBT_B_OVF   2

// ---------------------------------------------------------------
// Second bit-timing register fields
// ---------------------------------------------------------------
`define CFBT_B_WFIL  14
`define CFBT_B_PH2   8
`define CFBT_B_P2SEL 7
`define CFBT_B_SAM   6
`define CFBT_B_PH1   3
`define CFBT_B_PRS   0

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define CFBT_CFG2_RST  12'h000
`define CFBT_IEN_RST   5'h00
`define CFBT_IPT_TQ    2
`define CFBT_FILT_CYC  8

`endif

/* File: hdl/cfbt_pkg.sv */
package cfbt_pkg;

  typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} cfbt_seg_t;

  typedef struct packed {
    logic       wake_line_filter_sel;
    logic [2:0] phase_two_length;
    logic       phase_two_select;
    logic       triple_sample_sel;
    logic [2:0] phase_one_length;
    logic [2:0] propagation_length;
  } cfbt_cfg2_t;

  typedef struct packed {
    logic bad_message_flag;
    logic bus_wakeup_flag;
    logic error_event_flag;
    logic queue_almost_full_flag;
    logic rx_overflow_flag;
  } cfbt_flags_t;

  typedef struct packed {
    logic       tx_warn;
    logic       rx_warn;
    logic       bad_msg;
    logic [5:0] err_src;
    logic       fifo_af;
    logic       rx_ovf;
  } cfbt_evt_t;

  typedef struct packed {
    logic [2:0]  sync;
    logic        line;
    logic [1:0]  hist;
    logic        bus_bit;
    logic        sample_pt;
    logic        bit_start;
    cfbt_seg_t   seg;
    logic [2:0]  tq_cnt;
    logic [7:0]  filt_cnt;
    logic        wake_lvl;
    cfbt_cfg2_t  cfg;
    cfbt_flags_t flags;
    cfbt_flags_t ien;
    logic        ack;
    logic [15:0] rdata;
  } cfbt_state_t;

endpackage : cfbt_pkg

/* File: hdl/cfbt_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cfbt_regs.svh"

module cfbt_top
  import cfbt_pkg::*;
#(
  parameter int FILT_CYC = `CFBT_FILT_CYC,
  parameter int IPT_TQ   = `CFBT_IPT_TQ
) (
  input  wire logic        core_clk,        // 100 MHz clock
  input  wire logic        rst_n,           // Async reset, active low
  input  wire logic        ce,              // Clock enable, freezes all state
  input  wire logic [4:0]  avs_address,     // Byte address
  input  wire logic        avs_read,        // Read request
  input  wire logic        avs_write,       // Write request
  input  wire logic [31:0] avs_writedata,   // Write data
  input  wire logic [3:0]  avs_byteenable,  // Byte lanes
  output logic      [31:0] avs_readdata,    // Read data
  output logic             avs_waitrequest, // Stall
  input  wire cfbt_evt_t   evt,             // Engine events and states
  input  wire logic        sleep_mode,      // Controller asleep
  input  wire logic        tq_tick,         // One pulse per time quantum
  input  wire logic        can_rx,          // Bus line pin
  output logic             irq,             // Level interrupt
  output logic             sample_pt,       // Sample point pulse
  output logic             bit_start,       // Bit start pulse
  output logic             bus_bit          // Sampled bus value
);

  localparam logic [7:0] FILT_MAX = 8'(FILT_CYC - 1);
  localparam logic [2:0] IPT_CODE = 3'(IPT_TQ - 1);

  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  // The filter counter is eight bits and the phase codes three bits wide.
  if (FILT_CYC < 1 || FILT_CYC > 256) begin : g_filt_chk
    $error("FILT_CYC out of range");
  end
  if (IPT_TQ < 1 || IPT_TQ > 8) begin : g_ipt_chk
    $error("IPT_TQ out of range");
  end

  cfbt_state_t s_r;
  cfbt_state_t s_nxt;

  logic        req;
  logic        acc;
  logic        wr_acc;
  logic        dom;
  logic        wake_evt;
  logic        maj;
  logic [2:0]  seg_code;
  logic [2:0]  ph2_code;
  logic [15:0] flags_view;
  logic [15:0] cfg_view;
  logic [15:0] ien_view;
  logic [4:0]  set_v;
  logic [4:0]  clr_v;

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  // Every access takes two enabled cycles; the answer is one stall while ce stays high.
  assign req             = avs_read | avs_write;
  assign acc             = req & s_r.ack & ce;
  assign wr_acc          = acc & avs_write;
  assign avs_waitrequest = req & ~(s_r.ack & ce);
  assign avs_readdata    = {16'h0000, s_r.rdata};

  // ---------------------------------------------------------------
  // Derived timing and views
  // ---------------------------------------------------------------
  always_comb begin
    if (s_r.cfg.phase_two_select) begin
      ph2_code = s_r.cfg.phase_two_length;
    end else if (s_r.cfg.phase_one_length > IPT_CODE) begin
      ph2_code = s_r.cfg.phase_one_length;
    end else begin
      ph2_code = IPT_CODE;
    end
    case (s_r.seg)
      SEG_SYNC: seg_code = 3'h0;
      SEG_PROP: seg_code = s_r.cfg.propagation_length;
      SEG_PH1:  seg_code = s_r.cfg.phase_one_length;
      default:  seg_code = ph2_code;
    endcase
  end

  always_comb begin
    flags_view = 16'h0000;
    flags_view[`CFBT_B_ANY_ERROR_WARNING] = evt.tx_warn | evt.rx_warn;
    flags_view[`CFBT_B_BAD]   = s_r.flags.bad_message_flag;
    flags_view[`CFBT_B_WAKE]  = s_r.flags.bus_wakeup_flag;
    flags_view[`CFBT_B_ERR]   = s_r.flags.error_event_flag;
    flags_view[`CFBT_B_FIFO]  = s_r.flags.queue_almost_full_flag;
    flags_view[`CFBT_B_OVF]   = s_r.flags.rx_overflow_flag;
    ien_view = 16'h0000;
    ien_view[`CFBT_B_BAD]   = s_r.ien.bad_message_flag;
    ien_view[`CFBT_B_WAKE]  = s_r.ien.bus_wakeup_flag;
    ien_view[`CFBT_B_ERR]   = s_r.ien.error_event_flag;
    ien_view[`CFBT_B_FIFO]  = s_r.ien.queue_almost_full_flag;
    ien_view[`CFBT_B_OVF]   = s_r.ien.rx_overflow_flag;
    // Reserved bits are tied to zero here, not stored
    cfg_view = 16'h0000;
    cfg_view[`CFBT_B_WFIL]      = s_r.cfg.wake_line_filter_sel;
    cfg_view[`CFBT_B_PH2 +: 3]  = s_r.cfg.phase_two_length;
    cfg_view[`CFBT_B_P2SEL]     = s_r.cfg.phase_two_select;
    cfg_view[`CFBT_B_SAM]       = s_r.cfg.triple_sample_sel;
    cfg_view[`CFBT_B_PH1 +: 3]  = s_r.cfg.phase_one_length;
    cfg_view[`CFBT_B_PRS +: 3]  = s_r.cfg.propagation_length;
  end

  // ---------------------------------------------------------------
  // Wake-up detection
  // ---------------------------------------------------------------
  // Filtered wake needs FILT_CYC cycles of dominant level, so short
  // glitches on a sleeping bus do not wake the node.
  assign dom      = ~s_r.line & sleep_mode;
  assign wake_evt = dom & ~s_r.wake_lvl &
                    (~s_r.cfg.wake_line_filter_sel | (s_r.filt_cnt == FILT_MAX));
  // Majority of the two earlier quantum samples and the current line
  assign maj      = (s_r.hist[1] & s_r.hist[0]) | (s_r.hist[1] & s_r.line) |
                    (s_r.hist[0] & s_r.line);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    set_v = 5'h00;
    clr_v = 5'h00;
    s_nxt.sample_pt = 1'b0;
    s_nxt.bit_start = 1'b0;
    // The ack flop drops after each answer, so every access, back to back
    // or not, sees exactly one enabled stall cycle
    s_nxt.ack = req & ~s_r.ack;

    // Bus line synchroniser: change counted once stages two and three agree
    s_nxt.sync = {s_r.sync[1:0], can_rx};
    if (s_r.sync[2] == s_r.sync[1]) begin
      s_nxt.line = s_r.sync[2];
    end

    // Wake-up filter counter
    if (!dom) begin
      s_nxt.filt_cnt = 8'h00;
    end else if (s_r.filt_cnt != FILT_MAX) begin
      s_nxt.filt_cnt = s_r.filt_cnt + 8'h01;
    end
    s_nxt.wake_lvl = dom & (s_r.wake_lvl | wake_evt);

    // Bit-timing sequencer
    // A segment of code c lasts c plus one quanta; the sync quantum has code zero
    if (tq_tick) begin
      s_nxt.hist = {s_r.hist[0], s_r.line};
      if (s_r.tq_cnt >= seg_code) begin
        s_nxt.tq_cnt = 3'h0;
        case (s_r.seg)
          SEG_SYNC: s_nxt.seg = SEG_PROP;
          SEG_PROP: s_nxt.seg = SEG_PH1;
          SEG_PH1: begin
            s_nxt.seg       = SEG_PH2;
            s_nxt.sample_pt = 1'b1;
            s_nxt.bus_bit   = s_r.cfg.triple_sample_sel ? maj : s_r.line;
          end
          default: begin
            s_nxt.seg       = SEG_SYNC;
            s_nxt.bit_start = 1'b1;
          end
        endcase
      end else begin
        s_nxt.tq_cnt = s_r.tq_cnt + 3'h1;
      end
    end

    // Flag events; set beats a clear in the same cycle
    set_v = {evt.bad_msg,
             wake_evt,
             |evt.err_src,
             evt.fifo_af,
             evt.rx_ovf};

    // Register writes, address decode
    if (wr_acc) begin
      if (avs_address == `CFBT_OFS_FLAGS) begin
        if (avs_byteenable[0]) begin
          clr_v = ~{avs_writedata[`CFBT_B_BAD], avs_writedata[`CFBT_B_WAKE],
                    avs_writedata[`CFBT_B_ERR], avs_writedata[`CFBT_B_FIFO],
                    avs_writedata[`CFBT_B_OVF]};
        end
      end else if (avs_address == `CFBT_OFS_CFG2) begin
        if (avs_byteenable[1]) begin
          s_nxt.cfg.wake_line_filter_sel = avs_writedata[`CFBT_B_WFIL];
          s_nxt.cfg.phase_two_length     = avs_writedata[`CFBT_B_PH2 +: 3];
        end
        if (avs_byteenable[0]) begin
          s_nxt.cfg.phase_two_select   = avs_writedata[`CFBT_B_P2SEL];
          s_nxt.cfg.triple_sample_sel  = avs_writedata[`CFBT_B_SAM];
          s_nxt.cfg.phase_one_length   = avs_writedata[`CFBT_B_PH1 +: 3];
          s_nxt.cfg.propagation_length = avs_writedata[`CFBT_B_PRS +: 3];
        end
      end else if (avs_address == `CFBT_OFS_IEN) begin
        if (avs_byteenable[0]) begin
          s_nxt.ien = {avs_writedata[`CFBT_B_BAD], avs_writedata[`CFBT_B_WAKE],
                       avs_writedata[`CFBT_B_ERR], avs_writedata[`CFBT_B_FIFO],
                       avs_writedata[`CFBT_B_OVF]};
        end
      end else if (avs_address == `CFBT_OFS_ICLR) begin
        if (avs_byteenable[0]) begin
          clr_v = {avs_writedata[`CFBT_B_BAD], avs_writedata[`CFBT_B_WAKE],
                   avs_writedata[`CFBT_B_ERR], avs_writedata[`CFBT_B_FIFO],
                   avs_writedata[`CFBT_B_OVF]};
        end
      end
    end
    // Writing one has no effect, but a read-modify-write of the flag
    // register clears an event that arrived in between, as it read as zero
    s_nxt.flags = (s_r.flags & ~clr_v) | set_v;

    // Read data is captured at the edge that raises ack, so it already
    // stands while waitrequest is low; the register view is one cycle old
    if (avs_read && !s_r.ack) begin
      if (avs_address == `CFBT_OFS_FLAGS) begin
        s_nxt.rdata = flags_view;
      end else if (avs_address == `CFBT_OFS_CFG2) begin
        s_nxt.rdata = cfg_view;
      end else if (avs_address == `CFBT_OFS_IEN) begin
        s_nxt.rdata = ien_view;
      end else if (avs_address == `CFBT_OFS_STAT) begin
        s_nxt.rdata = {14'h0000, s_r.bus_bit, s_r.line};
      end else begin
        s_nxt.rdata = 16'h0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Timing fields reset to zero (CFBT_CFG2_RST), the shortest codes,
  // so the sequencer runs from reset before software programs them.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r           <= '0;
      s_r.sync      <= 3'h7;
      s_r.line      <= 1'b1;
      s_r.hist      <= 2'h3;
      s_r.bus_bit   <= 1'b1;
      s_r.cfg       <= cfbt_cfg2_t'(`CFBT_CFG2_RST);
      s_r.ien       <= cfbt_flags_t'(`CFBT_IEN_RST);
      s_r.flags     <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // Level interrupt straight from flops, so it cannot glitch
  assign irq       = |(s_r.flags & s_r.ien);
  assign sample_pt = s_r.sample_pt;
  assign bit_start = s_r.bit_start;
  assign bus_bit   = s_r.bus_bit;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // A request that sits through ce low is answered once ce returns; the
  // bus checks below rely on the stall being exactly one enabled cycle.

  logic tq_en;
  assign tq_en = ce & tq_tick;

  warn_status_a: assert property (
    acc && avs_read && avs_address == `CFBT_OFS_FLAGS && $past(ce)
    |-> avs_readdata[`CFBT_B_ANY_ERROR_WARNING] == $past(evt.tx_warn | evt.rx_warn))
    else $error("warning status bit wrong");
  bad_msg_set_a: assert property (
    ce && evt.bad_msg |=> s_r.flags.bad_message_flag)
    else $error("bad message flag not set");
  wake_set_a: assert property (
    ce && wake_evt |=> s_r.flags.bus_wakeup_flag)
    else $error("wake flag not set");
  error_set_a: assert property (
    ce && (evt.err_src != 6'h00) |=> s_r.flags.error_event_flag)
    else $error("error flag not set");
  unimpl_bits_a: assert property (
    acc && avs_read && avs_address == `CFBT_OFS_FLAGS |-> avs_readdata[4] == 1'b0)
    else $error("flag bit 4 not zero");
  fifo_set_a: assert property (
    ce && evt.fifo_af |=> s_r.flags.queue_almost_full_flag)
    else $error("fifo flag not set");
  ovf_set_a: assert property (
    ce && evt.rx_ovf |=> s_r.flags.rx_overflow_flag)
    else $error("overflow flag not set");
  wake_filter_a: assert property (
    s_r.cfg.wake_line_filter_sel && s_r.filt_cnt != FILT_MAX |-> !wake_evt)
    else $error("wake passed filter early");
  ph2_len_a: assert property (
    tq_en && s_r.seg == SEG_PH2 && s_r.tq_cnt < ph2_code |=> s_r.seg == SEG_PH2)
    else $error("phase two ended early");
  sample_one_a: assert property (
    tq_en && s_r.seg == SEG_PH1 && s_r.tq_cnt == s_r.cfg.phase_one_length
      && !s_r.cfg.triple_sample_sel |=> sample_pt && bus_bit == $past(s_r.line))
    else $error("single sample wrong");
  ph1_len_a: assert property (
    tq_en && s_r.seg == SEG_PH1 && s_r.tq_cnt < s_r.cfg.phase_one_length
    |=> s_r.seg == SEG_PH1)
    else $error("phase one ended early");
  prop_len_a: assert property (
    tq_en && s_r.seg == SEG_PROP && s_r.tq_cnt < s_r.cfg.propagation_length
    |=> s_r.seg == SEG_PROP)
    else $error("propagation ended early");
  cfg_zero_a: assert property (
    acc && avs_read && avs_address == `CFBT_OFS_CFG2
    |-> avs_readdata[15] == 1'b0 && avs_readdata[13:11] == 3'h0)
    else $error("timing reserved bits not zero");
  write_one_a: assert property (
    wr_acc && avs_address == `CFBT_OFS_FLAGS && avs_byteenable[0]
      && avs_writedata[`CFBT_B_OVF] && !evt.rx_ovf
    |=> s_r.flags.rx_overflow_flag == $past(s_r.flags.rx_overflow_flag))
    else $error("writing one changed a flag");
  sync_quantum_a: assert property (
    tq_en && s_r.seg == SEG_SYNC |=> s_r.seg == SEG_PROP)
    else $error("sync quantum longer than one");
  clear_zero_a: assert property (
    wr_acc && avs_address == `CFBT_OFS_FLAGS && avs_byteenable[0]
      && !avs_writedata[`CFBT_B_OVF] && !evt.rx_ovf
    |=> !s_r.flags.rx_overflow_flag)
    else $error("writing zero kept a flag");
  ph2_end_a: assert property (
    tq_en && s_r.seg == SEG_PH2 && s_r.tq_cnt >= ph2_code
    |=> s_r.seg == SEG_SYNC && bit_start)
    else $error("phase two did not end");
  triple_sample_a: assert property (
    tq_en && s_r.seg == SEG_PH1 && s_r.tq_cnt == s_r.cfg.phase_one_length
      && s_r.cfg.triple_sample_sel |=> sample_pt && bus_bit == $past(maj))
    else $error("triple sample wrong");
  flag_hold_a: assert property (
    ce && s_r.flags.bad_message_flag && !wr_acc |=> s_r.flags.bad_message_flag)
    else $error("flag dropped without a clear");
  first_stall_a: assert property (
    ce && req && !s_r.ack |-> avs_waitrequest)
    else $error("request answered without a stall");
  one_stall_a: assert property (
    ce && req && !s_r.ack |=> !req || !ce || !avs_waitrequest)
    else $error("second stall cycle");
  ce_freeze_a: assert property (
    !ce |=> $stable(s_r))
    else $error("state moved with clock enable low");

  wake_seen_c:   cover property (ce && wake_evt);
  triple_c:      cover property (sample_pt && s_r.cfg.triple_sample_sel);
  irq_rise_c:    cover property (!irq ##1 irq);
  flag_clear_c:  cover property (s_r.flags.bad_message_flag ##1 !s_r.flags.bad_message_flag);
  ce_stall_c:    cover property (!ce && req);

endmodule : cfbt_top
`default_nettype wire

/* File: verification/cfbt_bus_node.sv */
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// Far bus node: pull-up keeps the line recessive unless driven
// ---------------------------------------------------------------
module cfbt_bus_node (
  input  wire logic core_clk, // Clock
  output logic      can_rx    // Line level at the pin
);
  logic line_r = 1'b1;

  assign can_rx = line_r;

  task automatic dominant(input int n);
    @(posedge core_clk);
    line_r <= 1'b0;
    repeat (n) @(posedge core_clk);
    line_r <= 1'b1;
  endtask : dominant

  task automatic hold(input logic v);
    @(posedge core_clk);
    line_r <= v;
  endtask : hold
endmodule : cfbt_bus_node

`default_nettype wire

/* File: verification/cfbt_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cfbt_regs.svh"

`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", nm, e, s); end end

module testbench
  import cfbt_pkg::*;
;
  logic        core_clk, rst_n, ce, avs_read, avs_write, avs_waitrequest;
  logic        tq_tick, sleep_mode, irq, sample_pt, bit_start, bus_bit, can_rx;
  logic [4:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0]  tq_cnt_r;
  cfbt_evt_t   evt;
  int          fail_count, comparisons, cyc;

  cfbt_top #(.FILT_CYC(8), .IPT_TQ(2)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .evt(evt), .sleep_mode(sleep_mode),
    .tq_tick(tq_tick), .can_rx(can_rx), .irq(irq), .sample_pt(sample_pt),
    .bit_start(bit_start), .bus_bit(bus_bit));

  cfbt_bus_node i_bus (.core_clk(core_clk), .can_rx(can_rx));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // Quantum every fourth clock, so each quantum lasts 4 cycles
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    tq_cnt_r <= tq_cnt_r + 2'h1;
    tq_tick  <= (tq_cnt_r == 2'h3);
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------
  // Bus master: hold until waitrequest is sampled low; that edge answers
  // ---------------------------------------------------------------
  task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= {16'h0000, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata[15:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
    `CHK("waitrequest", 1'b1, n < 20)
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdchk(input string nm, input logic [4:0] a, input logic [15:0] e);
    logic [15:0] q;
    bus(1'b0, a, 16'h0000, q);
    `CHK(nm, e, q)
  endtask : rdchk

  task automatic evpulse(input logic [10:0] v);
    @(posedge core_clk);
    evt <= cfbt_evt_t'(v);
    @(posedge core_clk);
    evt <= '0;
  endtask : evpulse

  // Cycles until the next sample point (s=1) or bit start (s=0)
  task automatic pw(input logic s, output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (((s ? sample_pt : bit_start) !== 1'b1) && n < 400);
  endtask : pw

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rdchk("flags_rst", `CFBT_OFS_FLAGS, 16'h0000);
    rdchk("ien_rst", `CFBT_OFS_IEN, 16'h0000);
    `CHK("irq_rst", 1'b0, irq)
    $display("test reset done");
  endtask : t_reset

  task automatic t_flags();
    int eb;
    for (int j = 0; j < 9; j++) begin
      eb = (j == 8) ? 7 : (j >= 2) ? 5 : (j == 1) ? 3 : 2;
      evpulse(11'h001 << j);
      rdchk("flag_set", `CFBT_OFS_FLAGS, 16'h0001 << eb);
      wr(`CFBT_OFS_FLAGS, 16'hffff);
      rdchk("flag_w1", `CFBT_OFS_FLAGS, 16'h0001 << eb);
      wr(`CFBT_OFS_FLAGS, ~(16'h0001 << eb));
      rdchk("flag_w0", `CFBT_OFS_FLAGS, 16'h0000);
    end
    $display("test flags done");
  endtask : t_flags

  task automatic t_warn();
    @(posedge core_clk);
    evt <= cfbt_evt_t'(11'h400);
    rdchk("warn_tx", `CFBT_OFS_FLAGS, 16'h0100);
    evt <= cfbt_evt_t'(11'h200);
    rdchk("warn_rx", `CFBT_OFS_FLAGS, 16'h0100);
    evt <= '0;
    rdchk("warn_off", `CFBT_OFS_FLAGS, 16'h0000);
    $display("test warn done");
  endtask : t_warn

  task automatic t_irq();
    evpulse(11'h001);
    #1;
    `CHK("irq_masked", 1'b0, irq)
    wr(`CFBT_OFS_IEN, 16'h0004);
    `CHK("irq_on", 1'b1, irq)
    rdchk("iclr_rd", `CFBT_OFS_ICLR, 16'h0000);
    wr(`CFBT_OFS_IEN, 16'h0000);
    `CHK("irq_mask", 1'b0, irq)
    wr(`CFBT_OFS_IEN, 16'h0004);
    wr(`CFBT_OFS_ICLR, 16'h0004);
    `CHK("irq_clr", 1'b0, irq)
    rdchk("flag_iclr", `CFBT_OFS_FLAGS, 16'h0000);
    wr(5'h14, 16'hffff);
    rdchk("unmapped", 5'h14, 16'h0000);
    $display("test irq done");
  endtask : t_irq

  task automatic t_ce();
    wr(`CFBT_OFS_IEN, 16'h0004);
    ce <= 1'b0;
    evpulse(11'h001);
    `CHK("ce_irq", 1'b0, irq)
    fork
      rdchk("ce_flags", `CFBT_OFS_FLAGS, 16'h0000);
      begin
        repeat (6) @(posedge core_clk);
        `CHK("ce_stall", 1'b1, avs_waitrequest)
        ce <= 1'b1;
      end
    join
    wr(`CFBT_OFS_IEN, 16'h0000);
    $display("test ce done");
  endtask : t_ce

  task automatic t_lane();
    wr(`CFBT_OFS_CFG2, 16'h0000);
    avs_byteenable <= 4'h2;
    wr(`CFBT_OFS_CFG2, 16'h47ff);
    rdchk("cfg2_lane1", `CFBT_OFS_CFG2, 16'h4700);
    evpulse(11'h001);
    wr(`CFBT_OFS_FLAGS, 16'h0000);
    rdchk("flag_lane1", `CFBT_OFS_FLAGS, 16'h0004);
    avs_byteenable <= 4'h1;
    wr(`CFBT_OFS_CFG2, 16'h0000);
    rdchk("cfg2_lane0", `CFBT_OFS_CFG2, 16'h4700);
    wr(`CFBT_OFS_FLAGS, 16'h0000);
    rdchk("flag_lane0", `CFBT_OFS_FLAGS, 16'h0000);
    avs_byteenable <= 4'h3;
    $display("test lanes done");
  endtask : t_lane

  task automatic t_cfg2();
    wr(`CFBT_OFS_CFG2, 16'hffff);
    rdchk("cfg2_ones", `CFBT_OFS_CFG2, 16'h47ff);
    wr(`CFBT_OFS_CFG2, 16'hb8a5);
    rdchk("cfg2_mix", `CFBT_OFS_CFG2, 16'h00a5);
    $display("test cfg2 done");
  endtask : t_cfg2

  task automatic t_time(input logic [15:0] cfg, input int tot, input int ph2);
    int a, b;
    wr(`CFBT_OFS_CFG2, cfg);
    pw(1'b0, a);
    pw(1'b0, a);
    pw(1'b1, a);
    pw(1'b0, b);
    `CHK("bit_len", tot, a + b)
    `CHK("ph2_len", ph2, b)
    $display("test timing %h done", cfg);
  endtask : t_time

  task automatic t_sample();
    int n;
    wr(`CFBT_OFS_CFG2, 16'h03d1);
    i_bus.hold(1'b0);
    pw(1'b1, n);
    pw(1'b1, n);
    `CHK("bus_bit_dom", 1'b0, bus_bit)
    rdchk("stat_dom", `CFBT_OFS_STAT, 16'h0000);
    i_bus.hold(1'b1);
    pw(1'b1, n);
    pw(1'b1, n);
    `CHK("bus_bit_rec", 1'b1, bus_bit)
    $display("test sample done");
  endtask : t_sample

  task automatic t_wake();
    @(posedge core_clk);
    sleep_mode <= 1'b1;
    wr(`CFBT_OFS_CFG2, 16'h4391);
    i_bus.dominant(4);
    repeat (16) @(posedge core_clk);
    rdchk("wake_filt_short", `CFBT_OFS_FLAGS, 16'h0000);
    wr(`CFBT_OFS_CFG2, 16'h0391);
    i_bus.dominant(4);
    repeat (16) @(posedge core_clk);
    rdchk("wake_raw", `CFBT_OFS_FLAGS, 16'h0040);
    wr(`CFBT_OFS_FLAGS, 16'hffbf);
    wr(`CFBT_OFS_CFG2, 16'h4391);
    i_bus.dominant(20);
    repeat (16) @(posedge core_clk);
    rdchk("wake_filt_long", `CFBT_OFS_FLAGS, 16'h0040);
    sleep_mode <= 1'b0;
    $display("test wake done");
  endtask : t_wake

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h3;
    evt = '0;
    sleep_mode = 1'b0;
    tq_tick = 1'b0;
    tq_cnt_r = 2'h0;
    fail_count = 0;
    comparisons = 0;
    cyc = 0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_flags();
    t_warn();
    t_irq();
    t_ce();
    t_cfg2();
    t_lane();
    t_time(16'h0391, 4 * (1 + 2 + 3 + 4), 4 * 4);
    t_time(16'h07bf, 4 * (1 + 8 + 8 + 8), 4 * 8);
    t_time(16'h0700, 4 * (1 + 1 + 1 + 2), 4 * 2);
    t_sample();
    t_wake();
    test_done();
  end
endmodule : testbench

`default_nettype wire
